// file: design/response_store.sv
// Purpose: serial register words behind the spi frame logic
// Assumes: byte-wide writes, word reads with registered data
// Notes: word zero is hard zero and ignores writes
`timescale 1ns/1ps
module response_store #(
  parameter int NWORDS = spi_frame_pkg::WORDS
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // access
  store_if.store bus
);
  import spi_frame_pkg::*;

  typedef struct packed {
    logic [NWORDS-1:0][DATA_W-1:0] mem;
    logic [DATA_W-1:0] rd_data;
  } store_t;

  store_t s;
  store_t next_s;

  generate
    if (NWORDS != (1 << WORD_AW))
    begin : g_bad
      $error("response_store: NWORDS must match the word address width");
    end
  endgenerate

  always_comb
  begin
    next_s = s;
    next_s.rd_data = s.mem[bus.rd_addr];
    if (bus.wr_en && bus.wr_addr != '0)
    begin
      if (bus.wr_be[1])
        next_s.mem[bus.wr_addr][15:8] = bus.wr_data[15:8];
      if (bus.wr_be[0])
        next_s.mem[bus.wr_addr][7:0] = bus.wr_data[7:0];
    end
    next_s.mem[0] = '0;
  end

  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
      s <= '0;
    else
      s <= next_s;
  end

  assign bus.rd_data = s.rd_data;
endmodule

// file: design/spi_frame_pkg.sv
// Purpose: shared constants, types and helpers of the shared-bus spi frame slave
// Assumes: one 100 MHz system clock, spi pins already synchronous to it
// Notes: frame lengths are detected, never configured
package spi_frame_pkg;
  localparam int DATA_W = 16;
  localparam int TX_W = 21;
  localparam int WORD_AW = 5;
  localparam int WORDS = 32;
  localparam logic [4:0] LEN16 = 5'h10;
  localparam logic [4:0] LEN20 = 5'h14;
  localparam logic [4:0] LEN21 = 5'h15;
  localparam logic [4:0] CNT_MAX = 5'h1f;
  localparam logic [5:0] ZERO_ADDR = 6'h00;
  localparam logic [5:0] ERR_ADDR = 6'h24;
  localparam int FLAG_BIT = 9;
  localparam int SYNC_BIT = 15;
  localparam int RW_BIT = 14;
  localparam logic [7:0] FLAG_CLR_MASK = 8'h02;
  localparam logic [3:0] CRC_POLY = 4'h3;
  localparam logic [3:0] CRC_INIT = 4'hf;
  localparam int CLK_PERIOD_NS = 10;
  localparam int SETTLE_NS = 70;
  // least time, so round up
  localparam int SETTLE_CYC = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [2:0] {ST_IDLE = 3'b001, ST_FRAME = 3'b010, ST_SETTLE = 3'b100} state_t;
  typedef enum logic [1:0] {MODE16 = 2'h0, MODE20 = 2'h1, MODE21 = 2'h2} mode_t;

  // msb-first crc over one response word
  function automatic logic [3:0] crc4(input logic [15:0] d);
    logic [3:0] c;
    logic fb;
    c = CRC_INIT;
    for (int i = 15; i >= 0; i--)
    begin
      fb = c[3] ^ d[i];
      c = {c[2:0], 1'b0};
      if (fb)
        c = c ^ CRC_POLY;
    end
    return c;
  endfunction

  // sync, r/w, address and data byte of a received frame, whatever its length
  function automatic logic [15:0] frame_word(input logic [20:0] rx, input logic [4:0] n);
    case (n)
      LEN20: return rx[19:4];
      LEN21: return rx[20:5];
      default: return rx[15:0];
    endcase
  endfunction

  function automatic logic len_ok(input logic [4:0] n);
    return (n == LEN16) || (n == LEN20) || (n == LEN21);
  endfunction
endpackage

// file: design/spi_frame_slave.sv
// Purpose: spi slave frame logic for a sensor sharing sclk, mosi and miso with a second one
// Assumes: sclk, cs_n and mosi synchronous to sys_clk; master drives the bus
// Notes: frame length 16, 20 or 21 is learnt from each frame
// How it works
// - in 16-clock mode stray falls while deselected count and break the next frame
// - in 16-clock mode stray falls may discard or corrupt the buffered read response
// - reading address zero always answers all zeros
// - in 20-clock mode every stray fall while deselected raises the frame error flag
// - 20-clock frames keep read data intact if stray clock comes late
// - 20-clock responses carry a four-bit crc after the data
// - 21-clock frames ignore clock activity while deselected
// - frame error flag sits in bit 9 of the error word at 0x24
// - a set sync bit in the received frame raises the frame error flag
// - 21-clock response is data, crc, then the crc top bit again
`timescale 1ns/1ps
module spi_frame_slave (
  // clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // spi pins
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic mosi,
  output logic miso,
  output logic miso_oe,
  // status
  output logic frame_error
);
  import spi_frame_pkg::*;

  typedef struct packed {
    state_t state;
    mode_t mode;
    logic sclk_q;
    logic cs_q;
    logic [4:0] edges;
    logic [TX_W-1:0] rx;
    logic [TX_W-1:0] tx;
    logic [TX_W-1:0] held;
    logic [4:0] held_n;
    logic held_ok;
    logic stray;
    logic [3:0] settle;
    logic fetch;
    logic [WORD_AW-1:0] raddr;
    logic [DATA_W-1:0] resp;
    logic flag;
  } slave_t;

  slave_t s;
  slave_t next_s;
  store_if mem ();

  logic rise;
  logic fall;
  logic sel;
  logic cs_fall;
  logic cs_rise;
  logic stray_fall;
  logic [15:0] hw;
  logic [15:0] rw;
  logic commit;
  logic do_write;
  logic do_read;
  logic flag_set;
  logic flag_clr;
  logic [3:0] crc;

  response_store #(.NWORDS(WORDS)) u_store (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .bus(mem)
  );

  always_comb
  begin
    rise = sclk & ~s.sclk_q;
    fall = ~sclk & s.sclk_q;
    sel = ~cs_n & ~s.cs_q;
    cs_fall = s.cs_q & ~cs_n;
    cs_rise = ~s.cs_q & cs_n;
    stray_fall = fall & cs_n & s.cs_q;
    hw = frame_word(s.held, s.held_n);
    rw = frame_word(s.rx, s.edges);
    crc = crc4(s.resp);
    // a stray edge inside the settle window drops the frame, except in 21-clock mode
    commit = (s.state == ST_SETTLE) && ((s.settle == '0) || cs_fall) && s.held_ok
      && !s.stray;
    do_write = commit & hw[RW_BIT];
    do_read = commit & ~hw[RW_BIT];
    flag_clr = do_write && (hw[13:8] == ERR_ADDR) && ((hw[7:0] & FLAG_CLR_MASK) != '0);
    flag_set = 1'b0;
    mem.wr_en = do_write;
    mem.wr_addr = hw[13:9];
    mem.wr_be = hw[8] ? 2'b01 : 2'b10;
    mem.wr_data = {hw[7:0], hw[7:0]};
    // the new address goes out at commit so the word is ready when fetch samples it
    mem.rd_addr = do_read ? hw[13:9] : s.raddr;

    next_s = s;
    next_s.sclk_q = sclk;
    next_s.cs_q = cs_n;
    next_s.fetch = do_read;
    if (do_read)
      next_s.raddr = hw[13:9];
    if (rise && sel)
    begin
      next_s.rx = {s.rx[TX_W-2:0], mosi};
      if (s.edges != CNT_MAX)
        next_s.edges = 5'(s.edges + 5'h01);
    end
    if (fall && sel)
      next_s.tx = {s.tx[TX_W-2:0], 1'b0};
    if (stray_fall)
    begin
      case (s.mode)
        MODE16:
        begin
          // still counted, so the next frame ends with a wrong count
          if (s.edges != CNT_MAX)
            next_s.edges = 5'(s.edges + 5'h01);
          // a late stray edge slips the buffered answer by one bit
          if (s.state == ST_IDLE)
            next_s.resp = {s.resp[DATA_W-2:0], 1'b0};
        end
        MODE20:
          flag_set = 1'b1;
        default:
          ;
      endcase
      if ((s.state == ST_SETTLE) && (s.mode != MODE21))
        next_s.stray = 1'b1;
    end
    if (s.fetch)
    begin
      if (s.raddr == '0)
        next_s.resp = '0;
      else
      begin
        next_s.resp = mem.rd_data;
        if (s.raddr == ERR_ADDR[5:1])
          next_s.resp[FLAG_BIT] = s.flag;
      end
    end

    case (s.state)
      ST_IDLE:
      begin
        if (cs_fall)
        begin
          next_s.tx = {s.resp, crc, crc[3]};
          next_s.state = ST_FRAME;
        end
      end
      ST_FRAME:
      begin
        if (cs_rise)
        begin
          next_s.held = s.rx;
          next_s.held_n = s.edges;
          next_s.held_ok = len_ok(s.edges) & ~rw[SYNC_BIT];
          if (!len_ok(s.edges))
            flag_set = 1'b1;
          else if (rw[SYNC_BIT])
            flag_set = 1'b1;
          if (len_ok(s.edges))
            next_s.mode = (s.edges == LEN16) ? MODE16 :
              (s.edges == LEN20) ? MODE20 : MODE21;
          next_s.edges = '0;
          next_s.rx = '0;
          next_s.stray = 1'b0;
          next_s.settle = 4'(SETTLE_CYC - 1);
          next_s.state = ST_SETTLE;
        end
      end
      ST_SETTLE:
      begin
        if (cs_fall)
        begin
          next_s.tx = {s.resp, crc, crc[3]};
          next_s.state = ST_FRAME;
        end
        else if (s.settle == '0)
          next_s.state = ST_IDLE;
        else
          next_s.settle = 4'(s.settle - 4'h1);
      end
      default:
        next_s.state = ST_IDLE;
    endcase
    // an event in the clearing cycle survives
    next_s.flag = (s.flag & ~flag_clr) | flag_set;
  end

  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      s <= '0;
      s.state <= ST_IDLE;
      s.mode <= MODE21;
      s.sclk_q <= 1'b1;
      s.cs_q <= 1'b1;
    end
    else
      s <= next_s;
  end

  assign miso = s.tx[TX_W-1];
  assign miso_oe = ~cs_n;
  assign frame_error = s.flag;

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!resetn);

  sequence frame_end;
    s.state == ST_FRAME && cs_rise;
  endsequence

  sequence quiet_settle;
    cs_n [*7];
  endsequence

  a_bad_count_flag: assert property (frame_end and !len_ok(s.edges) |=> s.flag)
    else $error("wrong clock count did not raise the frame error flag");
  a_sync_bit_flag: assert property (frame_end and rw[SYNC_BIT] |=> s.flag)
    else $error("set sync bit did not raise the frame error flag");
  a_count_detect: assert property (frame_end and s.edges == LEN20 and !rw[SYNC_BIT]
    |=> s.mode == MODE20)
    else $error("20 clock frame not detected");
  a_stray_count: assert property (stray_fall && s.mode == MODE16 && s.edges < 5'h1e
    |=> s.edges == $past(s.edges) + 5'h01)
    else $error("stray edge not counted in 16 clock mode");
  a_quiet_21: assert property (stray_fall && s.mode == MODE21 && s.state == ST_IDLE
    && !s.fetch |=> $stable(s.resp) && !$rose(s.flag))
    else $error("deselected clock disturbed a 21 clock sensor");
  a_late_stray_20: assert property (stray_fall && s.mode == MODE20 && s.state == ST_IDLE
    && !s.fetch |=> $stable(s.resp))
    else $error("late stray edge corrupted 20 clock read data");
  a_settle_window: assert property (frame_end ##1 quiet_settle |=> s.state == ST_IDLE)
    else $error("settle window is not 70 ns");
  a_early_discard: assert property (s.state == ST_SETTLE && s.stray
    |-> !mem.wr_en && !commit ##1 !s.fetch)
    else $error("frame committed despite early stray edge");
  a_nop_zero: assert property (s.fetch && s.raddr == '0 |=> s.resp == '0)
    else $error("no-operation read did not return zero");
  a_resp_crc: assert property (s.state == ST_IDLE && cs_fall
    |=> s.tx[TX_W-1:1] == {$past(s.resp), crc4($past(s.resp))}
    && s.tx[0] == s.tx[4])
    else $error("response not followed by its crc and repeat bit");
endmodule

// file: design/store_if.sv
// Purpose: carrier between frame logic and the serial register store
// Assumes: widths from the package
// Notes: read data return one cycle after the address
`timescale 1ns/1ps
interface store_if;
  logic wr_en;
  logic [1:0] wr_be;
  logic [spi_frame_pkg::WORD_AW-1:0] wr_addr;
  logic [spi_frame_pkg::DATA_W-1:0] wr_data;
  logic [spi_frame_pkg::WORD_AW-1:0] rd_addr;
  logic [spi_frame_pkg::DATA_W-1:0] rd_data;
  modport ctrl (output wr_en, output wr_be, output wr_addr, output wr_data, output rd_addr,
    input rd_data);
  modport store (input wr_en, input wr_be, input wr_addr, input wr_data, input rd_addr,
    output rd_data);
endinterface

// file: verification/spi_master.sv
// Purpose: spi master model driving a bus shared by two sensors
// Assumes: pins change 1 ns after sys_clk rises
// Notes: sclk idles high; mosi is inverted when released
`timescale 1ns/1ps
module spi_master (
  // clock
  input wire logic sys_clk,
  // spi pins
  output logic sclk,
  output logic cs_n,
  output logic mosi,
  input wire logic miso
);
  initial
  begin
    sclk = 1'b1;
    cs_n = 1'b1;
    mosi = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  // n clocks, msb first; caller picks 21 on a shared bus
  task automatic frame(input int n, input logic [20:0] w, output logic [20:0] r,
    input int gap);
    r = '0;
    cs_n = 1'b0;
    tick(2);
    for (int i = 0; i < n; i++)
    begin
      // miso moves one cycle after each seen fall, so take it at the end of the high phase
      r[20-i] = miso; // last bit of 21 is not used for crc
      sclk = 1'b0;
      mosi = w[20-i];
      tick(2);
      sclk = 1'b1;
      tick(2);
    end
    cs_n = 1'b1;
    mosi = ~mosi;
    tick(gap);
  endtask

  // one pulse meant for the other sensor, then a wait well past the settle time
  task automatic stray();
    sclk = 1'b0;
    tick(2);
    sclk = 1'b1;
    tick(12);
  endtask
endmodule

// file: verification/tb.sv
// Purpose: self-checking bench of the shared-bus spi frame slave
// Assumes: a model of the store and response buffer tracks every frame
// Notes: stray pulses stand for traffic to the second sensor
`timescale 1ns/1ps
module tb;
  import spi_frame_pkg::*;
  logic sys_clk, resetn, sclk, cs_n, mosi, miso, miso_oe, frame_error;
  int n_mismatch = 0;
  int num_checks = 0;
  int mode = 21;
  int lens [3] = '{21, 20, 16};
  logic [15:0] mem [32];
  logic [15:0] resp = '0;
  logic flag = 1'b0;
  logic spoil = 1'b0;
  logic [31:0] seed = 32'd53473;
  logic [31:0] x;
  logic [20:0] r;

  spi_frame_slave u_spi_frame_slave (.sys_clk(sys_clk), .resetn(resetn), .sclk(sclk),
    .cs_n(cs_n), .mosi(mosi), .miso(miso), .miso_oe(miso_oe), .frame_error(frame_error));
  spi_master u_spi_master (.sys_clk(sys_clk), .sclk(sclk), .cs_n(cs_n), .mosi(mosi),
    .miso(miso));

  function automatic logic [3:0] crc(input logic [15:0] d);
    logic [3:0] c;
    c = CRC_INIT;
    for (int i = 15; i >= 0; i--)
      c = {c[2:0], 1'b0} ^ ((c[3] ^ d[i]) ? CRC_POLY : 4'h0);
    return c;
  endfunction

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic check(input logic [20:0] seen, input logic [20:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic stop_test();
    if (n_mismatch == 0 && num_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // s: sync bit sent high; rw: 1 write
  task automatic xfer(input int n, input logic s, input logic rw, input logic [5:0] a,
    input logic [7:0] d);
    logic [3:0] c;
    logic ok;
    c = crc(resp);
    u_spi_master.frame(n, {s, rw, a, d, 5'h00}, r, 12);
    check(r >> (21 - n), {resp, c, c[3]} >> (21 - n));
    ok = !s && !spoil && (n == 16 || n == 20 || n == 21);
    spoil = 1'b0;
    if (!ok)
      flag = 1'b1;
    else
    begin
      mode = n;
      if (rw && a == ERR_ADDR && d[1])
        flag = 1'b0;
      if (rw && a[5:1] != 5'h0)
      begin
        if (a[0])
          mem[a[5:1]][7:0] = d;
        else
          mem[a[5:1]][15:8] = d;
      end
      if (!rw)
        resp = (a[5:1] == 5'h0) ? 16'h0000 : mem[a[5:1]];
      if (!rw && a[5:1] == ERR_ADDR[5:1])
        resp[FLAG_BIT] = flag;
    end
    check(frame_error, flag);
    check(miso_oe, 1'b0);
  endtask

  task automatic stray();
    u_spi_master.stray();
    if (mode == 20)
      flag = 1'b1;
    if (mode == 16)
    begin
      spoil = 1'b1;
      resp = resp << 1;
    end
    check(frame_error, flag);
  endtask

  // a write hit by a stray pulse inside its settle window is dropped
  task automatic early_write(input int n, input logic [5:0] a, input logic [7:0] d);
    logic [3:0] c;
    c = crc(resp);
    u_spi_master.frame(n, {1'b0, 1'b1, a, d, 5'h00}, r, 2);
    check(r >> (21 - n), {resp, c, c[3]} >> (21 - n));
    mode = n;
    stray();
  endtask

  initial
  begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // the sensor drives miso exactly while it is selected
  always @(negedge sys_clk)
    if (resetn === 1'b1)
      check(miso_oe, !cs_n);

  initial
  begin
    #200000;
    n_mismatch++;
    stop_test();
  end

  initial
  begin
    resetn = 1'b0;
    foreach (mem[i])
      mem[i] = '0;
    repeat (2) @(posedge sys_clk);
    #1;
    resetn = 1'b1;
    u_spi_master.tick(2);
    xfer(21, 1'b0, 1'b1, ZERO_ADDR, 8'hff);
    foreach (lens[k])
    begin
      x = rnd();
      // each length starts with a clear flag, so every raise is seen
      xfer(lens[k], 1'b0, 1'b1, ERR_ADDR, FLAG_CLR_MASK);
      xfer(lens[k], 1'b0, 1'b1, 6'(4 * k + 2), x[7:0]);
      xfer(lens[k], 1'b0, 1'b1, 6'(4 * k + 3), x[15:8]);
      xfer(lens[k], 1'b0, 1'b0, 6'(4 * k + 2), 8'h00);
      stray();
      // in 16-clock mode the first read after the stray pulse has a wrong count and is discarded
      xfer(lens[k], 1'b0, 1'b0, ZERO_ADDR, 8'h00);
      xfer(lens[k], 1'b0, 1'b0, ZERO_ADDR, 8'h00);
      xfer(lens[k], 1'b0, 1'b0, ZERO_ADDR, 8'h00);
    end
    xfer(20, 1'b0, 1'b1, ERR_ADDR, FLAG_CLR_MASK);
    early_write(20, 6'h06, ~mem[3][15:8]);
    xfer(20, 1'b0, 1'b0, 6'h06, 8'h00);
    xfer(20, 1'b0, 1'b0, ZERO_ADDR, 8'h00);
    xfer(21, 1'b1, 1'b0, ZERO_ADDR, 8'h00);
    xfer(21, 1'b0, 1'b0, ERR_ADDR, 8'h00);
    xfer(21, 1'b0, 1'b1, ERR_ADDR, FLAG_CLR_MASK);
    xfer(21, 1'b0, 1'b0, ERR_ADDR, 8'h00);
    xfer(18, 1'b0, 1'b0, ZERO_ADDR, 8'h00);
    xfer(21, 1'b0, 1'b0, ZERO_ADDR, 8'h00);
    stop_test();
  end
endmodule
